// >>> core/cam_pkg.sv
// What this block does
// [RQ1] month register: bit 4 tens, bits 3..0 units, bits 7..5 read zero
// [RQ2] months count 01 to 09 then 10 to 12 in bcd; january after reset
// [RQ3] year register: two bcd digits in bits 7..4 and 3..0, reset to 00
// [RQ4] counters at 04h to 0ah stay frozen while an interface access runs
// [RQ5] one tick during the freeze is remembered and applied after release
// [RQ6] host finishes every time access within one second
// [RQ7] host reads or writes seconds through years in one burst
// [RQ8] host reads: pointer 04h via A2h, then seven reads via A3h, stop
// [RQ9] second match: bit 7 disables compare, default 1; bcd seconds 00 to 59
// [RQ10] minute match: bit 7 disables, default 1; tens bits 6..4, units 3..0
// [RQ11] hour match: bit 7 disables, default 1; bit 6 reads zero; bcd hour
// [RQ12] 12-hour: bit 5 afternoon, bit 4 tens; 24-hour: bits 5..4 tens
// [RQ13] format select input picks 12-hour or 24-hour hour interpretation
// [RQ14] flag sets when all enabled match fields first equal the time
// [RQ15] february gets day 29 when the bcd year divides by 4, 00 included
// [RQ16] december rolls to january and bumps the year, 99 wraps to 00
package cam_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SEC    = 8'h04;
  localparam logic [7:0] ADDR_MIN    = 8'h05;
  localparam logic [7:0] ADDR_HOUR   = 8'h06;
  localparam logic [7:0] ADDR_DAY    = 8'h07;
  localparam logic [7:0] ADDR_WDAY   = 8'h08;
  localparam logic [7:0] ADDR_MON    = 8'h09;
  localparam logic [7:0] ADDR_YEAR   = 8'h0a;
  localparam logic [7:0] ADDR_SEC_AL = 8'h0b;
  localparam logic [7:0] ADDR_MIN_AL = 8'h0c;
  localparam logic [7:0] ADDR_HR_AL  = 8'h0d;

  // ---------------------------------------------------------------
  // implemented bits of each register
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_SEC    = 8'h7f;
  localparam logic [7:0] MASK_MIN    = 8'h7f;
  localparam logic [7:0] MASK_HOUR   = 8'h3f;
  localparam logic [7:0] MASK_DAY    = 8'h3f;
  localparam logic [7:0] MASK_WDAY   = 8'h07;
  localparam logic [7:0] MASK_MON    = 8'h1f;
  localparam logic [7:0] MASK_YEAR   = 8'hff;
  localparam logic [7:0] MASK_SEC_AL = 8'hff;
  localparam logic [7:0] MASK_MIN_AL = 8'hff;
  localparam logic [7:0] MASK_HR_AL  = 8'hbf;
  localparam logic [7:0] MASK_HR_CMP = 8'h3f;
  localparam logic [7:0] MASK_MS_CMP = 8'h7f;
  localparam int         MATCH_OFF_BIT = 7;
  localparam int         PM_BIT        = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SEC   = 8'h00;
  localparam logic [7:0] RST_MIN   = 8'h00;
  localparam logic [7:0] RST_HOUR  = 8'h00;
  localparam logic [7:0] RST_DAY   = 8'h01;
  localparam logic [7:0] RST_WDAY  = 8'h06;
  localparam logic [7:0] RST_MON   = 8'h01;
  localparam logic [7:0] RST_YEAR  = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'h80;
  localparam logic [7:0] RD_NONE   = 8'h00;

  // ---------------------------------------------------------------
  // counting limits, all bcd
  // ---------------------------------------------------------------
  localparam logic [7:0] TOP_SEC   = 8'h59;
  localparam logic [7:0] TOP_MIN   = 8'h59;
  localparam logic [7:0] TOP_H24   = 8'h23;
  localparam logic [7:0] TOP_WDAY  = 8'h06;
  localparam logic [7:0] TOP_MON   = 8'h12;
  localparam logic [7:0] TOP_YEAR  = 8'h99;
  localparam logic [7:0] LOW_ZERO  = 8'h00;
  localparam logic [7:0] LOW_ONE   = 8'h01;
  localparam logic [7:0] DAYS_28   = 8'h28;
  localparam logic [7:0] DAYS_29   = 8'h29;
  localparam logic [7:0] DAYS_30   = 8'h30;
  localparam logic [7:0] DAYS_31   = 8'h31;
  localparam logic [4:0] MON_FEB   = 5'h02;
  localparam logic [4:0] MON_APR   = 5'h04;
  localparam logic [4:0] MON_JUN   = 5'h06;
  localparam logic [4:0] MON_SEP   = 5'h09;
  localparam logic [4:0] MON_NOV   = 5'h11;
  localparam logic [4:0] H12_ONE   = 5'h01;
  localparam logic [4:0] H12_TEN   = 5'h10;
  localparam logic [4:0] H12_ELVN  = 5'h11;
  localparam logic [4:0] H12_TWLV  = 5'h12;
  localparam logic [3:0] NIB_ZERO  = 4'h0;
  localparam logic [3:0] NIB_ONE   = 4'h1;
  localparam logic [3:0] NIB_NINE  = 4'h9;

  // ---------------------------------------------------------------
  // generic counter field indices
  // ---------------------------------------------------------------
  localparam int FLD_SEC  = 0;
  localparam int FLD_MIN  = 1;
  localparam int FLD_HOUR = 2;
  localparam int FLD_DAY  = 3;
  localparam int FLD_WDAY = 4;
  localparam int FLD_MON  = 5;
  localparam int FLD_YEAR = 6;
  localparam int FLD_NUM  = 7;
  localparam int AL_NUM   = 3;

endpackage : cam_pkg

// >>> core/cam_bcd_inc.sv
module cam_bcd_inc
  import cam_pkg::*;
(
  input  wire logic [7:0] cur_val,
  input  wire logic [7:0] top_val,
  input  wire logic [7:0] low_val,
  output logic      [7:0] nxt_val,
  output logic            wrap
);

  // a value written above the top wraps at once instead of running on
  always_comb
  begin
    wrap    = (cur_val >= top_val);
    nxt_val = cur_val;
    if (wrap)
    begin
      nxt_val = low_val;
    end
    else if (cur_val[3:0] >= NIB_NINE)
    begin
      nxt_val = {cur_val[7:4] + NIB_ONE, NIB_ZERO};
    end
    else
    begin
      nxt_val = {cur_val[7:4], cur_val[3:0] + NIB_ONE};
    end
  end

endmodule : cam_bcd_inc

// >>> core/cam_top.sv
module cam_top
  import cam_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       tick_1hz,
  input  wire logic       acc_busy,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       fmt_12h,
  input  wire logic       match_clr,
  output logic      [7:0] reg_rdata,
  output logic            match_flag,
  output logic            inc_pending
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [7:0] day_q;
  logic [7:0] wday_q;
  logic [7:0] month_count_q;
  logic [7:0] year_count_q;
  logic [7:0] sec_match_reg_q;
  logic [7:0] min_match_reg_q;
  logic [7:0] hr_match_reg_q;
  logic       pend_q;
  logic       flag_q;
  logic       match_prev_q;
  logic [7:0] rdata_q;

  logic [7:0] f_cur  [FLD_NUM];
  logic [7:0] f_top  [FLD_NUM];
  logic [7:0] f_low  [FLD_NUM];
  logic [7:0] f_nxt  [FLD_NUM];
  logic       f_wrap [FLD_NUM];
  logic [7:0] hour_nxt;
  logic       hour_wrap;
  logic       do_inc;
  logic       match_now;
  logic [AL_NUM-1:0] al_on;
  logic [AL_NUM-1:0] al_hit;
  logic [7:0] al_reg  [AL_NUM];
  logic [7:0] al_time [AL_NUM];
  logic [7:0] al_mask [AL_NUM];

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  // odd tens digits pair with units 2 or 6, even ones with 0, 4 or 8
  function automatic logic is_leap(input logic [7:0] yr);
    is_leap = yr[4] ? ((yr[3:0] == 4'h2) || (yr[3:0] == 4'h6))
                    : ((yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8));
  endfunction : is_leap

  function automatic logic [7:0] month_len(input logic [4:0] m, input logic [7:0] yr);
    if (m == MON_FEB)
    begin
      month_len = is_leap(yr) ? DAYS_29 : DAYS_28; // RQ15
    end
    else if ((m == MON_APR) || (m == MON_JUN) || (m == MON_SEP) || (m == MON_NOV))
    begin
      month_len = DAYS_30;
    end
    else
    begin
      month_len = DAYS_31;
    end
  endfunction : month_len

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      ADDR_SEC:    rd_mux = sec_q & MASK_SEC;
      ADDR_MIN:    rd_mux = min_q & MASK_MIN;
      ADDR_HOUR:   rd_mux = hour_q & MASK_HOUR;
      ADDR_DAY:    rd_mux = day_q & MASK_DAY;
      ADDR_WDAY:   rd_mux = wday_q & MASK_WDAY;
      ADDR_MON:    rd_mux = month_count_q & MASK_MON; // RQ1
      ADDR_YEAR:   rd_mux = year_count_q & MASK_YEAR; // RQ3
      ADDR_SEC_AL: rd_mux = sec_match_reg_q & MASK_SEC_AL;
      ADDR_MIN_AL: rd_mux = min_match_reg_q & MASK_MIN_AL;
      ADDR_HR_AL:  rd_mux = hr_match_reg_q & MASK_HR_AL; // RQ11
      default:     rd_mux = RD_NONE;
    endcase
  endfunction : rd_mux

  // ---------------------------------------------------------------
  // increment request and hold
  // ---------------------------------------------------------------
  // the host is expected to finish inside one second, so one bit is enough
  assign do_inc = !acc_busy && (tick_1hz || pend_q); // RQ4

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
    end
    else if (acc_busy)
    begin
      if (tick_1hz)
      begin
        pend_q <= 1'b1; // RQ5 RQ6
      end
    end
    else
    begin
      // a tick on the release cycle with one pending keeps one queued
      pend_q <= tick_1hz && pend_q; // RQ5
    end
  end

  // ---------------------------------------------------------------
  // per-field bcd incrementers
  // ---------------------------------------------------------------
  assign f_cur[FLD_SEC]  = sec_q;
  assign f_cur[FLD_MIN]  = min_q;
  assign f_cur[FLD_HOUR] = hour_q;
  assign f_cur[FLD_DAY]  = day_q;
  assign f_cur[FLD_WDAY] = wday_q;
  assign f_cur[FLD_MON]  = month_count_q;
  assign f_cur[FLD_YEAR] = year_count_q;

  assign f_top[FLD_SEC]  = TOP_SEC;
  assign f_top[FLD_MIN]  = TOP_MIN;
  assign f_top[FLD_HOUR] = TOP_H24;
  assign f_top[FLD_DAY]  = month_len(month_count_q[4:0], year_count_q); // RQ15
  assign f_top[FLD_WDAY] = TOP_WDAY;
  assign f_top[FLD_MON]  = TOP_MON; // RQ2
  assign f_top[FLD_YEAR] = TOP_YEAR; // RQ16

  assign f_low[FLD_SEC]  = LOW_ZERO;
  assign f_low[FLD_MIN]  = LOW_ZERO;
  assign f_low[FLD_HOUR] = LOW_ZERO;
  assign f_low[FLD_DAY]  = LOW_ONE;
  assign f_low[FLD_WDAY] = LOW_ZERO;
  assign f_low[FLD_MON]  = LOW_ONE; // RQ2
  assign f_low[FLD_YEAR] = LOW_ZERO; // RQ16

  for (genvar gi = 0; gi < FLD_NUM; gi++)
  begin : g_fld
    cam_bcd_inc u_inc (
      .cur_val (f_cur[gi]),
      .top_val (f_top[gi]),
      .low_val (f_low[gi]),
      .nxt_val (f_nxt[gi]),
      .wrap    (f_wrap[gi])
    );
  end

  // ---------------------------------------------------------------
  // hour step, both formats
  // ---------------------------------------------------------------
  always_comb
  begin
    hour_nxt  = f_nxt[FLD_HOUR];
    hour_wrap = f_wrap[FLD_HOUR];
    if (fmt_12h) // RQ13
    begin
      hour_wrap = 1'b0;
      if (hour_q[4:0] == H12_ELVN)
      begin
        // 11 to 12 flips the half day; only 11 pm to 12 am ends the day
        hour_nxt  = {2'b00, ~hour_q[PM_BIT], H12_TWLV}; // RQ12
        hour_wrap = hour_q[PM_BIT];
      end
      else if (hour_q[4:0] >= H12_TWLV)
      begin
        hour_nxt = {2'b00, hour_q[PM_BIT], H12_ONE}; // RQ12
      end
      else if (hour_q[3:0] >= NIB_NINE)
      begin
        hour_nxt = {2'b00, hour_q[PM_BIT], H12_TEN};
      end
      else
      begin
        hour_nxt = {2'b00, hour_q[PM_BIT], hour_q[4], hour_q[3:0] + NIB_ONE};
      end
    end
  end

  // ---------------------------------------------------------------
  // time counters 04h..0ah
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sec_q         <= RST_SEC;
      min_q         <= RST_MIN;
      hour_q        <= RST_HOUR;
      day_q         <= RST_DAY;
      wday_q        <= RST_WDAY;
      month_count_q <= RST_MON; // RQ2
      year_count_q  <= RST_YEAR; // RQ3
    end
    else
    begin
      if (do_inc) // RQ4 RQ5
      begin
        sec_q <= f_nxt[FLD_SEC];
        if (f_wrap[FLD_SEC])
        begin
          min_q <= f_nxt[FLD_MIN];
          if (f_wrap[FLD_MIN])
          begin
            hour_q <= hour_nxt;
            if (hour_wrap)
            begin
              day_q  <= f_nxt[FLD_DAY];
              wday_q <= f_nxt[FLD_WDAY];
              if (f_wrap[FLD_DAY])
              begin
                month_count_q <= f_nxt[FLD_MON]; // RQ2
                if (f_wrap[FLD_MON])
                begin
                  year_count_q <= f_nxt[FLD_YEAR]; // RQ16
                end
              end
            end
          end
        end
      end
      // a write wins over a tick; normally both cannot meet since writes are busy
      if (reg_wr)
      begin
        case (reg_addr)
          ADDR_SEC:  sec_q         <= reg_wdata & MASK_SEC;
          ADDR_MIN:  min_q         <= reg_wdata & MASK_MIN;
          ADDR_HOUR: hour_q        <= reg_wdata & MASK_HOUR;
          ADDR_DAY:  day_q         <= reg_wdata & MASK_DAY;
          ADDR_WDAY: wday_q        <= reg_wdata & MASK_WDAY;
          ADDR_MON:  month_count_q <= reg_wdata & MASK_MON; // RQ1
          ADDR_YEAR: year_count_q  <= reg_wdata & MASK_YEAR; // RQ3
          default:   ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // match registers 0bh..0dh
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sec_match_reg_q <= RST_MATCH; // RQ9
      min_match_reg_q <= RST_MATCH; // RQ10
      hr_match_reg_q  <= RST_MATCH; // RQ11
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_SEC_AL: sec_match_reg_q <= reg_wdata & MASK_SEC_AL; // RQ9
        ADDR_MIN_AL: min_match_reg_q <= reg_wdata & MASK_MIN_AL; // RQ10
        ADDR_HR_AL:  hr_match_reg_q  <= reg_wdata & MASK_HR_AL; // RQ11
        default:     ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // match compare
  // ---------------------------------------------------------------
  assign al_reg[0]  = sec_match_reg_q;
  assign al_reg[1]  = min_match_reg_q;
  assign al_reg[2]  = hr_match_reg_q;
  assign al_time[0] = sec_q;
  assign al_time[1] = min_q;
  assign al_time[2] = hour_q;
  assign al_mask[0] = MASK_MS_CMP;
  assign al_mask[1] = MASK_MS_CMP;
  // hour compare covers afternoon bit and both tens layouts alike
  assign al_mask[2] = MASK_HR_CMP; // RQ12

  for (genvar ai = 0; ai < AL_NUM; ai++)
  begin : g_al
    assign al_on[ai]  = ~al_reg[ai][MATCH_OFF_BIT]; // RQ9 RQ10 RQ11
    assign al_hit[ai] = ~al_on[ai] ||
                        ((al_reg[ai] & al_mask[ai]) == (al_time[ai] & al_mask[ai])); // RQ14
  end

  assign match_now = (&al_hit) && (|al_on); // RQ14

  // ---------------------------------------------------------------
  // match flag: set on the first matching moment, set beats clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flag_q       <= 1'b0;
      match_prev_q <= 1'b0;
    end
    else
    begin
      match_prev_q <= match_now;
      if (match_now && !match_prev_q)
      begin
        flag_q <= 1'b1; // RQ14
      end
      else if (match_clr)
      begin
        flag_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_q <= RD_NONE;
    end
    else if (reg_rd)
    begin
      rdata_q <= rd_mux(reg_addr);
    end
  end

  assign reg_rdata   = rdata_q;
  assign match_flag  = flag_q;
  assign inc_pending = pend_q;

endmodule : cam_top

// >>> tb/cam_checker.sv
module cam_checker
  import cam_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       tick_1hz,
  input wire logic       acc_busy,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic       match_clr,
  input wire logic [7:0] reg_rdata,
  input wire logic       match_flag,
  input wire logic       inc_pending
);
  timeunit 1ns;
  timeprecision 100ps;

  logic evt;

  // ---------------------------------------------------------------
  // anything that can move the counters
  // ---------------------------------------------------------------
  assign evt = tick_1hz | reg_wr | inc_pending;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  month_unused_a: assert property (reg_rd && reg_addr == ADDR_MON |=> reg_rdata[7:5] == 3'h0)
    else $error("month unused bits not zero");
  month_code_a: assert property (reg_rd && reg_addr == ADDR_MON
    |=> reg_rdata[4:0] inside {[5'h01:5'h09], [5'h10:5'h12]})
    else $error("month code out of range");
  year_bcd_a: assert property (reg_rd && reg_addr == ADDR_YEAR
    |=> reg_rdata[7:4] <= 4'h9 && reg_rdata[3:0] <= 4'h9)
    else $error("year digit not bcd");
  hr_unused_a: assert property (reg_rd && reg_addr == ADDR_HR_AL |=> !reg_rdata[6])
    else $error("hour match bit 6 set");
  pend_take_a: assert property (acc_busy && tick_1hz |=> inc_pending)
    else $error("tick during access not stored");
  pend_keep_a: assert property (acc_busy && inc_pending |=> inc_pending)
    else $error("stored tick lost while frozen");
  pend_apply_a: assert property (!acc_busy && inc_pending && !tick_1hz |=> !inc_pending)
    else $error("stored tick not applied on release");
  flag_keep_a: assert property (match_flag && !match_clr |=> match_flag)
    else $error("match flag dropped without clear");
  flag_cause_a: assert property ($rose(match_flag) |-> $past(evt, 2))
    else $error("match flag rose without a time change");

  cover property ($rose(match_flag));
  cover property (acc_busy && tick_1hz);
  cover property (inc_pending && !acc_busy);
endmodule : cam_checker

// >>> tb/cam_host_model.sv
module cam_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic            acc_busy,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle cycles after each byte; nonzero gives a slow host
  int gap = 0;

  initial
  begin
    acc_busy = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // ---------------------------------------------------------------
  // access framing: one burst per start/stop pair
  // ---------------------------------------------------------------
  task automatic start_acc();
    @(negedge clk_sys);
    acc_busy = 1'b1;
  endtask : start_acc

  // bursts are a few dozen cycles, far below one second
  task automatic stop_acc();
    @(negedge clk_sys);
    acc_busy = 1'b0;
  endtask : stop_acc

  // released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    repeat (gap) @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    repeat (gap) @(negedge clk_sys);
  endtask : rd
endmodule : cam_host_model

// >>> tb/test_calendar_access_and_alarm_match.sv
module test_calendar_access_and_alarm_match
  import cam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_sys, rst, tick_1hz, fmt_12h, match_clr;
  logic       acc_busy, reg_wr, reg_rd, match_flag, inc_pending;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  int         failures, check_count, y;
  int         t[7];
  int         msk[7] = '{'h7f, 'h7f, 'h3f, 'h3f, 'h07, 'h1f, 'hff};
  int         al[4][3] = '{'{'h90, 'hb0, 'hb1}, '{'h10, 'h30, 'h72},
                           '{'h10, 'h30, 'h71}, '{'h10, 'h30, 'hf2}};
  logic [7:0] al_exp[4] = '{8'h00, 8'h00, 8'h01, 8'h01};

  cam_top uut (.clk_sys(clk_sys), .rst(rst), .tick_1hz(tick_1hz), .acc_busy(acc_busy),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .fmt_12h(fmt_12h), .match_clr(match_clr), .reg_rdata(reg_rdata),
    .match_flag(match_flag), .inc_pending(inc_pending));

  cam_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .acc_busy(acc_busy),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // reference calendar, bcd held in integers
  // ---------------------------------------------------------------
  function automatic bit bump(input int i, input int top, input int low);
    bit w;
    w = t[i] >= top;
    t[i] = w ? low : ((t[i] & 15) == 9 ? t[i] + 7 : t[i] + 1);
    return w;
  endfunction : bump

  // 12-hour step: 12, 1 .. 11; 11 to 12 flips the half day, 11 pm ends the day
  function automatic bit hr12();
    int pm;
    int h;
    pm = t[2] & 'h20;
    h = t[2] & 'h1f;
    h = (h >= 'h12) ? 1 : ((h & 15) == 9 ? h + 7 : h + 1);
    if (h == 'h12)
      pm = pm ^ 'h20;
    t[2] = pm | h;
    return h == 'h12 && pm == 0;
  endfunction : hr12

  function automatic void adv();
    int yr;
    int top;
    yr = (t[6] >> 4) * 10 + (t[6] & 15);
    top = (t[5] == 2) ? ((yr % 4 == 0) ? 'h29 : 'h28) :
          (t[5] inside {4, 6, 9, 'h11}) ? 'h30 : 'h31;
    if (bump(0, 'h59, 0) && bump(1, 'h59, 0) && (fmt_12h ? hr12() : bump(2, 'h23, 0)))
    begin
      void'(bump(4, 6, 0));
      if (bump(3, top, 1) && bump(5, 'h12, 1))
        void'(bump(6, 'h99, 0));
    end
  endfunction : adv

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input bit apply);
    @(negedge clk_sys);
    tick_1hz = 1'b1;
    @(negedge clk_sys);
    tick_1hz = 1'b0;
    if (apply)
      adv();
  endtask : tick

  task automatic clear_flag();
    @(negedge clk_sys);
    match_clr = 1'b1;
    @(negedge clk_sys);
    match_clr = 1'b0;
  endtask : clear_flag

  task automatic set_time(input int v[7]);
    host.start_acc();
    for (int i = 0; i < 7; i++)
    begin
      host.wr(ADDR_SEC + 8'(i), 8'(v[i]));
      t[i] = v[i] & msk[i];
    end
    host.stop_acc();
  endtask : set_time

  task automatic read_cmp();
    logic [7:0] q;
    for (int i = 0; i < 7; i++)
    begin
      host.rd(ADDR_SEC + 8'(i), q);
      check(q, 8'(t[i]));
    end
  endtask : read_cmp

  task automatic check_time();
    host.start_acc();
    read_cmp();
    host.stop_acc();
  endtask : check_time

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    tick_1hz = 1'b0;
    fmt_12h = 1'b0;
    match_clr = 1'b0;
    failures = 0;
    check_count = 0;
    t = '{0, 0, 0, 1, 6, 1, 0};
    void'($urandom(80844));
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    check_time();
    for (int a = 'h0b; a <= 'h0e; a++)
    begin
      host.rd(8'(a), d);
      check(d, a == 'h0e ? 8'h00 : 8'h80);
    end
    $display("test reset_values done");
    // upper month bits written as ones must be dropped
    set_time('{'h59, 'h59, 'h23, 'h31, 6, 'hf2, 'h99});
    tick(1'b1);
    check_time();
    $display("test year_wrap done");
    for (int k = 0; k < 3; k++)
    begin
      y = (k == 0) ? 0 : $urandom % 100;
      set_time('{'h59, 'h59, 'h23, 'h28, 3, 2, ((y / 10) << 4) | (y % 10)});
      tick(1'b1);
      check_time();
    end
    $display("test leap_year done");
    host.gap = 3;
    host.start_acc();
    tick(1'b0);
    tick(1'b0);
    check(inc_pending, 8'h01);
    read_cmp();
    host.stop_acc();
    adv();
    @(negedge clk_sys);
    check(inc_pending, 8'h00);
    check_time();
    host.gap = 0;
    $display("test access_freeze done");
    fmt_12h = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      set_time('{'h09, 'h30, 'h31, 1, 1, 1, 0});
      for (int j = 0; j < 3; j++)
        host.wr(ADDR_SEC_AL + 8'(j), 8'(al[k][j]));
      clear_flag();
      tick(1'b1);
      @(negedge clk_sys);
      check(match_flag, al_exp[k]);
      host.rd(ADDR_HR_AL, d);
      check(d, 8'(al[k][2] & 'hbf));
    end
    clear_flag();
    check(match_flag, 8'h00);
    $display("test alarm_match done");
    // 11 pm rolls to 12 am with a day carry, 11 am to 12 pm without
    for (int k = 0; k < 2; k++)
    begin
      set_time('{'h59, 'h59, k ? 'h11 : 'h31, 'h28, 3, 2, 1});
      tick(1'b1);
      check_time();
    end
    $display("test hour_12h done");
    end_of_test();
  end
endmodule : test_calendar_access_and_alarm_match

bind cam_top cam_checker u_chk (.clk_sys(clk_sys), .rst(rst), .tick_1hz(tick_1hz),
  .acc_busy(acc_busy), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .match_clr(match_clr), .reg_rdata(reg_rdata), .match_flag(match_flag),
  .inc_pending(inc_pending));
